// File: hdl/toq_pkg.sv
package toq_pkg;

	// One timed entry: output-state byte, sequence number, microsecond stamp.
	typedef struct packed
	{
		logic [7:0] state;
		logic [7:0] seq;
		logic [15:0] stamp;
	} toq_entry_t;

	// Access path for the diagnostic record.
	typedef enum logic [1:0] {TOQ_PATH_RS, TOQ_PATH_CAN, TOQ_PATH_ECAT} toq_path_t;

	// One diagnostic read request.
	typedef struct packed
	{
		toq_path_t path;
		logic [15:0] index;
		logic [7:0] sub;
		logic [4:0] byte_idx;
	} toq_diag_req_t;

	localparam int BATCH = 15;
	localparam int QDEPTH = 32;
	localparam int SEQ_LAST_BIT = 6;
	localparam int CHANNELS = 4;
	localparam int STATE_MSB = 7;

	localparam logic [7:0] MODULE_INFO = 8'h1f;
	localparam logic [7:0] CHANNEL_KIND = 8'h72;
	localparam logic [7:0] DIAG_BITS = 8'h00;
	localparam logic [7:0] CHANNEL_COUNT = 8'h04;
	localparam logic [7:0] RSVD_BYTE = 8'h00;

	localparam logic [4:0] OFS_MODULE_INFO = 5'h01;
	localparam logic [4:0] OFS_CHANNEL_KIND = 5'h04;
	localparam logic [4:0] OFS_DIAG_BITS = 5'h05;
	localparam logic [4:0] OFS_CHANNEL_COUNT = 5'h06;
	localparam logic [4:0] OFS_STAMP = 5'h10;
	localparam logic [4:0] LEN_FULL = 5'h14;
	localparam logic [4:0] LEN_SHORT = 5'h04;
	localparam logic [4:0] STAMP_LEN = 5'h04;

	localparam logic [15:0] RS_FULL = 16'h0001;
	localparam logic [15:0] RS_SHORT = 16'h0000;
	localparam logic [15:0] IX_FULL = 16'h2f01;
	localparam logic [15:0] IX_SHORT = 16'h2f00;
	localparam logic [15:0] ECAT_IX = 16'h5005;
	localparam logic [7:0] SX_FIRST = 8'h02;
	localparam logic [7:0] SX_LAST_BYTE = 8'h11;
	localparam logic [7:0] SX_STAMP = 8'h13;

endpackage

// File: hdl/toq_timed_output.sv
//Contract
// R01 - Queued entries are driven in order and removed once their state is applied.
// R02 - Host marks a short batch by setting bit 6 of the final sequence number.
// R03 - The block raises no interrupts; diagnostics are information only.
// R04 - Record set 01h returns the whole record, record set 00h the first four bytes.
// R05 - CANopen index 2F01h gives the whole record, 2F00h the first four bytes.
// R06 - EtherCAT index 5005h gives one subindex per field, starting at 02h.
// R07 - Record order fixed; every reserved byte reads 00h.
// R08 - Module information byte reads 1Fh: digital class, channel information present.
// R09 - Channel kind reads 72h, digital output, bit 7 zero.
// R10 - Diagnostic bits per channel reads 00h.
// R11 - Channel count reads 04h.
// R12 - Timestamp field holds the 32-bit ticker captured when the record is generated.
// R13 - Host must supply a microsecond ticker for timed outputs to work.
// R14 - Image moves into the queue only after the full batch of fifteen is written; the code also commits on any write whose sequence number has bit 6 set.
// R15 - Each entry is four bytes of the output image.
// R16 - An entry's state is applied when the ticker reaches its stamp.
module toq_timed_output #(
	parameter int BATCH = toq_pkg::BATCH,
	parameter int QDEPTH = toq_pkg::QDEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] us_ticker,
	input wire logic img_wr,
	input wire logic [3:0] img_slot,
	input wire toq_pkg::toq_entry_t img_entry,
	input wire logic diag_req,
	input wire toq_pkg::toq_diag_req_t diag_sel,
	output logic img_ready,
	output logic [toq_pkg::CHANNELS-1:0] do_out,
	output logic [5:0] queued_entry_count,
	output logic [7:0] last_written_sequence,
	output logic diag_valid,
	output logic diag_err,
	output logic [7:0] diag_data
);

	typedef enum logic {TOQ_COLLECT, TOQ_DRAIN} toq_state_t;
	localparam int QW = $clog2(QDEPTH);

	// Map a request to a record byte offset; bit 5 flags a valid request.
	function automatic logic [5:0] toq_map(toq_pkg::toq_diag_req_t r);
		logic [5:0] m;
		m = 6'h00;
		case (r.path)
			// R04 record set numbers
			// R05 CANopen object indices
			toq_pkg::TOQ_PATH_RS, toq_pkg::TOQ_PATH_CAN:
			begin
				if ((r.index == (r.path == toq_pkg::TOQ_PATH_RS ? toq_pkg::RS_FULL : toq_pkg::IX_FULL)
					&& r.byte_idx < toq_pkg::LEN_FULL) ||
					(r.index == (r.path == toq_pkg::TOQ_PATH_RS ? toq_pkg::RS_SHORT : toq_pkg::IX_SHORT)
					&& r.byte_idx < toq_pkg::LEN_SHORT))
					m = {1'b1, r.byte_idx};
			end
			// R06 EtherCAT subindex map
			toq_pkg::TOQ_PATH_ECAT:
			begin
				if (r.index == toq_pkg::ECAT_IX && r.sub >= toq_pkg::SX_FIRST
					&& r.sub <= toq_pkg::SX_LAST_BYTE && r.byte_idx == 5'h00)
					m = {1'b1, 5'(r.sub - toq_pkg::SX_FIRST)};
				else if (r.index == toq_pkg::ECAT_IX && r.sub == toq_pkg::SX_STAMP
					&& r.byte_idx < toq_pkg::STAMP_LEN)
					m = {1'b1, 5'(toq_pkg::OFS_STAMP + r.byte_idx)};
			end
			default: m = 6'h00;
		endcase
		return m;
	endfunction

	// Byte of the record at an offset; the stamp is sent most significant byte first.
	function automatic logic [7:0] toq_byte(logic [4:0] ofs, logic [31:0] ts);
		logic [7:0] b;
		b = toq_pkg::RSVD_BYTE;
		case (ofs)
			// R08 module information byte
			toq_pkg::OFS_MODULE_INFO: b = toq_pkg::MODULE_INFO;
			// R09 digital output kind
			toq_pkg::OFS_CHANNEL_KIND: b = toq_pkg::CHANNEL_KIND;
			// R10 no diagnostic bits
			toq_pkg::OFS_DIAG_BITS: b = toq_pkg::DIAG_BITS;
			// R11 four channels
			toq_pkg::OFS_CHANNEL_COUNT: b = toq_pkg::CHANNEL_COUNT;
			default:
			begin
				if (ofs >= toq_pkg::OFS_STAMP)
					b = ts[8*(3-int'(ofs[1:0])) +: 8];
			end
		endcase
		return b;
	endfunction

	toq_pkg::toq_entry_t image [BATCH];
	toq_pkg::toq_entry_t sb_mem [2];
	toq_pkg::toq_entry_t queue [QDEPTH];
	logic [BATCH-1:0] mask_reg, mask_next;
	toq_state_t state_reg, state_next;
	logic [3:0] drain_reg, drain_next, drain_len_reg;
	logic sb_wp_reg, sb_rp_reg;
	logic [1:0] sb_cnt_reg;
	logic [QW:0] q_wp_reg, q_rp_reg;
	logic [31:0] snap_reg, snap_next;

	// Image collection: a write is taken only while the image is open.
	wire logic wr_take = img_wr && img_ready && (int'(img_slot) < BATCH);
	wire logic wr_last = wr_take && img_entry.seq[toq_pkg::SEQ_LAST_BIT];
	// R14 batch complete commit
	wire logic commit = wr_take && ((&(mask_reg | (BATCH'(1) << img_slot))) || wr_last);

	// Two-entry buffer between image drain and queue; a full queue stalls the drain.
	wire logic sb_in_valid = (state_reg == TOQ_DRAIN);
	wire logic sb_in_ready = (sb_cnt_reg != 2'h2);
	wire logic sb_push = sb_in_valid && sb_in_ready;
	wire logic q_full = (q_wp_reg - q_rp_reg) == (QW+1)'(QDEPTH);
	wire logic q_empty = (q_wp_reg == q_rp_reg);
	wire logic sb_out_valid = (sb_cnt_reg != 2'h0);
	wire logic sb_out_ready = !q_full;
	wire logic q_push = sb_out_valid && sb_out_ready;
	wire toq_pkg::toq_entry_t q_head = queue[q_rp_reg[QW-1:0]];
	// R16 stamp match
	wire logic q_pop = !q_empty && (q_head.stamp == us_ticker[15:0]);

	// Drain sequencing: a short batch drains slot zero up to the marked slot.
	always_comb
	begin
		state_next = state_reg;
		drain_next = drain_reg;
		mask_next = mask_reg;
		if (state_reg == TOQ_COLLECT && commit)
		begin
			state_next = TOQ_DRAIN;
			drain_next = 4'h0;
		end
		else if (state_reg == TOQ_COLLECT && wr_take)
			mask_next = mask_reg | (BATCH'(1) << img_slot);
		else if (state_reg == TOQ_DRAIN && sb_push)
		begin
			drain_next = drain_reg + 4'h1;
			if (drain_reg == drain_len_reg)
			begin
				state_next = TOQ_COLLECT;
				mask_next = '0;
			end
		end
	end

	// State registers; img_ready follows the next state, so writes after a commit are refused.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= TOQ_COLLECT;
			drain_reg <= 4'h0;
			drain_len_reg <= 4'h0;
			mask_reg <= '0;
			img_ready <= 1'b1;
			last_written_sequence <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			drain_reg <= drain_next;
			mask_reg <= mask_next;
			img_ready <= (state_next == TOQ_COLLECT);
			if (commit)
				drain_len_reg <= wr_last ? img_slot : 4'(BATCH - 1);
			if (wr_take)
				last_written_sequence <= img_entry.seq;
		end
	end

	// Image store has no reset; a short batch drains every slot from zero to the marked slot, written or not.
	always_ff @(posedge clk)
	begin
		if (wr_take)
			image[img_slot] <= img_entry;
		if (sb_push)
			sb_mem[sb_wp_reg] <= image[drain_reg];
		if (q_push)
			queue[q_wp_reg[QW-1:0]] <= sb_mem[sb_rp_reg];
	end

	// R01 in-order queue
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sb_wp_reg <= 1'b0;
			sb_rp_reg <= 1'b0;
			sb_cnt_reg <= 2'h0;
			q_wp_reg <= '0;
			q_rp_reg <= '0;
			do_out <= '0;
			queued_entry_count <= 6'h00;
		end
		else
		begin
			sb_wp_reg <= sb_wp_reg ^ sb_push;
			sb_rp_reg <= sb_rp_reg ^ q_push;
			sb_cnt_reg <= sb_cnt_reg + 2'(sb_push) - 2'(q_push);
			q_wp_reg <= q_wp_reg + (QW+1)'(q_push);
			q_rp_reg <= q_rp_reg + (QW+1)'(q_pop);
			queued_entry_count <= 6'(q_wp_reg + (QW+1)'(q_push) - q_rp_reg - (QW+1)'(q_pop));
			if (q_pop)
				do_out <= q_head.state[toq_pkg::STATE_MSB -: toq_pkg::CHANNELS];
		end
	end

	// Diagnostic read: a request for byte zero regenerates the record stamp.
	wire logic [5:0] diag_map = toq_map(diag_sel);
	// R12 stamp capture
	assign snap_next = (diag_req && diag_sel.byte_idx == 5'h00) ? us_ticker : snap_reg;

	// R03 read without side effects
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			snap_reg <= 32'h0000_0000;
			diag_valid <= 1'b0;
			diag_err <= 1'b0;
			diag_data <= 8'h00;
		end
		else
		begin
			snap_reg <= snap_next;
			diag_valid <= diag_req;
			diag_err <= diag_req && !diag_map[5];
			// R07 reserved bytes zero
			if (diag_req)
				diag_data <= diag_map[5] ? toq_byte(diag_map[4:0], snap_next) : 8'h00;
		end
	end

	// Request shapes reused by the diagnostic checks below.
	sequence s_req_rs(logic [15:0] ix, logic [4:0] b);
		diag_req && diag_sel.path == toq_pkg::TOQ_PATH_RS && diag_sel.index == ix
			&& diag_sel.byte_idx == b;
	endsequence

	a_diag_answer: assert property (@(posedge clk) disable iff (rst) // R03
		diag_req |=> diag_valid ##1 !diag_valid || $past(diag_req))
		else $error("diagnostic answer missing");
	a_modinfo_byte: assert property (@(posedge clk) disable iff (rst) // R08
		s_req_rs(toq_pkg::RS_FULL, toq_pkg::OFS_MODULE_INFO) |=> diag_data == 8'h1f && !diag_err)
		else $error("module information byte wrong");
	a_kind_byte: assert property (@(posedge clk) disable iff (rst) // R09
		s_req_rs(toq_pkg::RS_FULL, toq_pkg::OFS_CHANNEL_KIND) |=> diag_data == 8'h72)
		else $error("channel kind byte wrong");
	a_count_bytes: assert property (@(posedge clk) disable iff (rst) // R11
		s_req_rs(toq_pkg::RS_FULL, toq_pkg::OFS_CHANNEL_COUNT) |=> diag_data == 8'h04)
		else $error("channel count byte wrong");
	a_short_set: assert property (@(posedge clk) disable iff (rst) // R04
		s_req_rs(toq_pkg::RS_SHORT, toq_pkg::OFS_CHANNEL_KIND) |=> diag_err && diag_data == 8'h00)
		else $error("short record set longer than four bytes");
	a_can_full: assert property (@(posedge clk) disable iff (rst) // R05
		diag_req && diag_sel.path == toq_pkg::TOQ_PATH_CAN && diag_sel.index == 16'h2f01
			&& diag_sel.byte_idx < 5'h14 |=> !diag_err)
		else $error("canopen full record refused");
	a_ecat_first: assert property (@(posedge clk) disable iff (rst) // R06
		diag_req && diag_sel.path == toq_pkg::TOQ_PATH_ECAT && diag_sel.index == 16'h5005
			&& diag_sel.sub == 8'h03 && diag_sel.byte_idx == 5'h00 |=> diag_data == 8'h1f)
		else $error("ethercat subindex mapping wrong");
	a_stamp_capture: assert property (@(posedge clk) disable iff (rst) // R12
		s_req_rs(toq_pkg::RS_FULL, 5'h13) |=> diag_data == $past(snap_reg[7:0]))
		else $error("stamp low byte not from captured ticker");
	a_pop_time: assert property (@(posedge clk) disable iff (rst) // R16
		$changed(do_out) |-> $past(q_pop) && $past(q_head.stamp) == $past(us_ticker[15:0]))
		else $error("outputs changed without a due entry");
	a_batch_hold: assert property (@(posedge clk) disable iff (rst) // R14
		state_reg == TOQ_COLLECT && !commit |=> state_reg == TOQ_COLLECT)
		else $error("image moved before batch complete");
	a_no_overflow: assert property (@(posedge clk) disable iff (rst) // R01
		q_full |=> !(q_wp_reg - q_rp_reg > (QW+1)'(QDEPTH)))
		else $error("queue overflow");

	// EtherCAT request shape; the stamp subindex takes byte_idx 0 to 3.
	sequence s_req_ecat(logic [7:0] sx, logic [4:0] b);
		diag_req && diag_sel.path == toq_pkg::TOQ_PATH_ECAT && diag_sel.index == toq_pkg::ECAT_IX
			&& diag_sel.sub == sx && diag_sel.byte_idx == b;
	endsequence

	a_diagbits_byte: assert property (@(posedge clk) disable iff (rst) // R10
		s_req_rs(toq_pkg::RS_FULL, toq_pkg::OFS_DIAG_BITS) |=> diag_data == 8'h00 && !diag_err)
		else $error("diagnostic bit count byte wrong");
	a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // R07
		s_req_rs(toq_pkg::RS_FULL, 5'h00) |=> diag_data == 8'h00 && !diag_err)
		else $error("reserved record byte not zero");
	a_short_accept: assert property (@(posedge clk) disable iff (rst) // R04
		s_req_rs(toq_pkg::RS_SHORT, 5'h03) |=> !diag_err && diag_data == 8'h00)
		else $error("short record set refused a leading byte");
	a_ecat_count: assert property (@(posedge clk) disable iff (rst) // R06
		s_req_ecat(8'h08, 5'h00) |=> diag_data == 8'h04 && !diag_err)
		else $error("ethercat channel count subindex wrong");
	a_stamp_first: assert property (@(posedge clk) disable iff (rst) // R12
		s_req_ecat(8'h13, 5'h00) |=> diag_data == $past(us_ticker[31:24]))
		else $error("stamp not taken at record generation");
	a_ready_drain: assert property (@(posedge clk) disable iff (rst) // R14
		commit |=> !img_ready)
		else $error("image still open after batch commit");
	a_out_hold: assert property (@(posedge clk) disable iff (rst) // R16
		!q_pop |=> $stable(do_out))
		else $error("outputs moved without a due entry");

endmodule // toq_timed_output

// File: dv/toq_head_model.sv
module toq_head_model (
	input wire logic clk,
	input wire logic rst,
	output logic [31:0] us_ticker
);
	timeunit 1ns;
	timeprecision 1ps;
	// ticker supplied
	// One tick a clock keeps stamps close; the start sits just below a 16-bit wrap.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			us_ticker <= 32'hfffe_ff80;
		else
			us_ticker <= us_ticker + 32'h1;
	end
endmodule // toq_head_model

// File: dv/timed_output_queue_diag_test.sv
module timed_output_queue_diag_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, img_wr, diag_req, img_ready, diag_valid, diag_err;
	logic [3:0] img_slot, do_out;
	logic [31:0] us_ticker, cap, rnd;
	logic [15:0] tp;
	logic [5:0] queued_entry_count;
	logic [7:0] last_written_sequence, diag_data;
	toq_pkg::toq_entry_t img_entry;
	toq_pkg::toq_diag_req_t diag_sel;
	logic [8:0] dq[$];
	logic [19:0] oq[$];
	int mismatches, comparisons;
	toq_timed_output #(.QDEPTH(8)) DUT (.clk(clk), .rst(rst), .us_ticker(us_ticker),
		.img_wr(img_wr), .img_slot(img_slot), .img_entry(img_entry), .diag_req(diag_req),
		.diag_sel(diag_sel), .img_ready(img_ready), .do_out(do_out),
		.queued_entry_count(queued_entry_count), .last_written_sequence(last_written_sequence),
		.diag_valid(diag_valid), .diag_err(diag_err), .diag_data(diag_data));
	toq_head_model head (.clk(clk), .rst(rst), .us_ticker(us_ticker));
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Expected record byte; the stamp goes out most significant byte first.
	function automatic logic [7:0] rec(input int i);
		case (i)
			1: return 8'h1f;
			4: return 8'h72;
			6: return 8'h04;
			16, 17, 18, 19: return cap[8*(19-i)+:8];
			default: return 8'h00;
		endcase
	endfunction
	task automatic rd(input logic [1:0] p, input logic [15:0] ix, input logic [7:0] sx,
		input int b, input int ri);
		@(posedge clk);
		#1 diag_req = 1'b1;
		diag_sel = {p, ix, sx, b[4:0]};
		if (b == 0)
			cap = us_ticker;
		dq.push_back(ri < 0 ? 9'h100 : {1'b0, rec(ri)});
	endtask
	// One step of the bench's xorshift generator.
	function automatic logic [31:0] xorshift(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic wr(input int s, input logic [7:0] sq, input logic [15:0] st);
		@(posedge clk);
		#1 img_wr = 1'b1;
		rnd = xorshift(rnd);
		img_slot = s[3:0];
		img_entry = {rnd[7:0], sq, st};
		oq.push_back({st, rnd[7:4]});
	endtask
	task automatic idle(input int n);
		@(posedge clk);
		#1 img_wr = 1'b0;
		diag_req = 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Bounded wait until every noted result has been seen and the image is open again.
	task automatic drain();
		int n;
		n = 0;
		while ((oq.size() != 0 || dq.size() != 0 || img_ready !== 1'b1) && n < 4000)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 4000)
		begin
			mismatches++;
			$display("BAD drain expected empty seen timeout");
			end_of_test();
		end
	endtask
	// Free-running bench clock.
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Takes the oldest note whenever an answer or an output step appears.
	initial
	begin
		forever
		begin
			@(negedge clk);
			tp = us_ticker[15:0] - 16'h0001; // The ticker has already stepped past the stamp.
			if (diag_valid === 1'b1)
			begin
				if (dq.size() != 0)
					chk("diag", {diag_err, diag_data}, dq.pop_front());
				else
					chk("diag extra", 32'h1, 32'h0);
			end
			if (oq.size() != 0 && oq[0][19:4] == tp)
			begin
				chk("do_out", do_out, 32'(oq[0][3:0]));
				oq.delete(0);
			end
		end
	end
	// Main sequence.
	initial
	begin
		logic [15:0] t;
		rst = 1'b1;
		img_wr = 1'b0;
		diag_req = 1'b0;
		img_slot = 4'h0;
		img_entry = '0;
		diag_sel = '0;
		rnd = 32'h0000_004d;
		cap = '0;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 20; i++) rd(2'h0, 16'h0001, 8'h00, i, i);
		for (int i = 0; i < 5; i++) rd(2'h0, 16'h0000, 8'h00, i, i < 4 ? i : -1);
		for (int i = 0; i < 20; i++) rd(2'h1, 16'h2f01, 8'h00, i, i);
		for (int i = 0; i < 5; i++) rd(2'h1, 16'h2f00, 8'h00, i, i < 4 ? i : -1);
		for (int s = 2; s < 18; s++) rd(2'h2, 16'h5005, s[7:0], 0, s - 2);
		for (int i = 0; i < 4; i++) rd(2'h2, 16'h5005, 8'h13, i, 16 + i);
		rd(2'h2, 16'h5005, 8'h12, 0, -1);
		rd(2'h1, 16'h1234, 8'h00, 0, -1);
		idle(2);
		$display("test diag done");
		t = us_ticker[15:0] + 16'h00c8;
		for (int i = 0; i < 14; i++) wr(i, i[7:0] + 8'h01, t + 16'(i * 40 - i / 3 * 39));
		idle(3);
		chk("count", queued_entry_count, 32'h0);
		wr(14, 8'h0f, t + 16'h0259);
		idle(2);
		chk("ready", img_ready, 32'h0);
		idle(20);
		chk("count full", queued_entry_count, 32'h8);
		drain();
		chk("count", queued_entry_count, 32'h0);
		$display("test full batch done");
		t = us_ticker[15:0] + 16'h0064;
		for (int i = 0; i < 3; i++)
			wr(i, 8'h10 + i[7:0] | (i == 2 ? 8'h40 : 8'h00), t + 16'(i * 30));
		idle(1);
		chk("last seq", last_written_sequence, 32'h52);
		drain();
		chk("count", queued_entry_count, 32'h0);
		$display("test short batch done");
		end_of_test();
	end
endmodule // timed_output_queue_diag_test
